// *** rtl/sdcc_clkgen.v ***
// Card clock divider: kernel clock / (factor + 2), or a toggle per cycle
// in bypass. Assumes run_i already folds enable, gating and stalls.
`timescale 1ns/1ps
`include "sdcc_defs.vh"

module sdcc_clkgen (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire       run_i,
  input  wire [7:0] div_i,
  input  wire       bypass_i,
  input  wire       edge_i,
  output reg        card_clk_o,
  output wire       drive_tick_o,
  output wire       sample_tick_o
);

  reg  [8:0] cnt_q;
  reg        lvl_q;
  reg        lvl_d;
  wire [8:0] period;
  wire [8:0] half;
  wire       at_rise;
  wire       at_fall;

  assign period  = {1'b0, div_i} + 9'h002;
  assign half    = {1'b0, period[8:1]};
  assign at_rise = bypass_i ? ~lvl_q : (cnt_q == period - 9'h001);
  assign at_fall = bypass_i ? lvl_q  : (cnt_q == half - 9'h001);
  // Ticks mark the kernel cycle just before the card clock changes
  assign sample_tick_o = run_i & at_rise;
  assign drive_tick_o  = run_i & at_fall;

  always @* begin
    lvl_d = lvl_q;
    if (!run_i) begin
      lvl_d = 1'b0;
    end else if (at_rise) begin
      lvl_d = 1'b1;
    end else if (at_fall) begin
      lvl_d = 1'b0;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q      <= 9'h000;
      lvl_q      <= 1'b0;
      card_clk_o <= 1'b0;
    end else if (ce_i) begin
      lvl_q      <= lvl_d;
      // Inverted phase stands in for the opposite kernel edge
      card_clk_o <= run_i & (lvl_d ^ edge_i);
      if (!run_i || bypass_i || at_rise) begin
        cnt_q <= 9'h000;
      end else begin
        cnt_q <= cnt_q + 9'h001;
      end
    end
  end

endmodule

// *** rtl/sdcc_crc7.v ***
// Serial CRC7 (x^7 + x^3 + 1) shared by command transmit and receive.
// Assumes the caller clears it before each frame and never enables
// accumulate and shift-out in the same cycle.
`timescale 1ns/1ps
`include "sdcc_defs.vh"

module sdcc_crc7 (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire       clr_i,
  input  wire       en_i,
  input  wire       shift_i,
  input  wire       din_i,
  output wire [6:0] crc_o
);

  reg  [6:0] crc_q;
  wire       fb;

  assign fb    = din_i ^ crc_q[6];
  assign crc_o = crc_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_q <= 7'h00;
    end else if (ce_i) begin
      if (clr_i) begin
        crc_q <= 7'h00;
      end else if (en_i) begin
        crc_q <= {crc_q[5:3], crc_q[2] ^ fb, crc_q[1:0], fb};
      end else if (shift_i) begin
        crc_q <= {crc_q[5:0], 1'b0};
      end
    end
  end

endmodule

// *** rtl/sdcc_defs.vh ***
// Register offsets, field positions, reset values and timing counts for
// the card clock and command path. Included by every design file.
`ifndef SDCC_DEFS_VH
`define SDCC_DEFS_VH

// Word offsets, byte addressed
`define SDCC_OFF_CLKCTRL   8'h04
`define SDCC_OFF_ARG       8'h08
`define SDCC_OFF_CMD       8'h0c
`define SDCC_OFF_RESPIDX   8'h10

// Card clock control fields
`define SDCC_CLK_DIV_MSB   7
`define SDCC_CLK_EN        8
`define SDCC_CLK_GATE      9
`define SDCC_CLK_BYPASS    10
`define SDCC_CLK_WID_LSB   11
`define SDCC_CLK_WID_MSB   12
`define SDCC_CLK_EDGE      13
`define SDCC_CLK_FLOW      14
`define SDCC_CLK_MSB       14

// Command control fields
`define SDCC_CMD_IDX_MSB   5
`define SDCC_CMD_WAIT_LSB  6
`define SDCC_CMD_WAIT_MSB  7
`define SDCC_CMD_WAITIRQ   8
`define SDCC_CMD_WAITEND   9
`define SDCC_CMD_ENABLE    10
`define SDCC_CMD_SUSPEND   11
`define SDCC_CMD_CPL       12
`define SDCC_CMD_IRQEN     13
`define SDCC_CMD_ATA       14
`define SDCC_CMD_MSB       14

// Reset values
`define SDCC_RST_CLKCTRL   15'h0000
`define SDCC_RST_ARG       32'h0000_0000
`define SDCC_RST_CMD       15'h0000
`define SDCC_RST_RESPIDX   6'h00

// Bus width codes
`define SDCC_WID_1         2'h0
`define SDCC_WID_4         2'h1
`define SDCC_LANES_1       8'h01
`define SDCC_LANES_4       8'h0f
`define SDCC_LANES_8       8'hff

// Frame lengths and CRC bit ranges in card clock bits
`define SDCC_CMD_BITS      8'h30
`define SDCC_SHORT_BITS    8'h30
`define SDCC_LONG_BITS     8'h88
`define SDCC_SHORT_CRC_LO  8'h00
`define SDCC_SHORT_CRC_HI  8'h27
`define SDCC_LONG_CRC_LO   8'h08
`define SDCC_LONG_CRC_HI   8'h7f

// Response timeout in card clock cycles
`define SDCC_RESP_TIMEOUT  8'h40

`endif

// *** rtl/sdcc_top.v ***
// Card clock generator and command path with its word registers.
// Assumes word-wide register access and inputs synchronous to ref_clk_i.
`timescale 1ns/1ps
`include "sdcc_defs.vh"

module sdcc_top (
  input  wire        ref_clk_i,
  input  wire        rstn_i,
  input  wire        ce_i,
  input  wire        reg_sel_i,
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        data_busy_i,
  input  wire        data_stall_i,
  input  wire        read_wait_stop_i,
  input  wire        card_irq_i,
  input  wire        cmd_i,
  output reg         cmd_o,
  output reg         cmd_oe_o,
  output wire        card_clk_o,
  output reg  [7:0]  data_lanes_o,
  output reg         flow_ctrl_en_o,
  output reg         cmd_irq_en_o,
  output reg         busy_o,
  output reg         suspend_cmd_o,
  output reg         ata_cmd_o,
  output reg         cmd_sent_o,
  output reg         resp_recv_o,
  output reg         resp_crc_fail_o,
  output reg         resp_timeout_o,
  output reg         irq_seen_o,
  output reg         cmd_done_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PEND = 3'h1;
  localparam [2:0] ST_SEND = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  localparam [2:0] ST_RECV = 3'h4;

  // ==========================================================
  // Reset release
  reg [1:0] rst_sync_q;
  wire      rst_n;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Registers
  reg  [`SDCC_CLK_MSB:0] clkctrl_q;
  reg  [31:0]            arg_q;
  reg  [`SDCC_CMD_MSB:0] cmd_q;
  reg  [5:0]             resp_idx_q;
  reg  [2:0]             state_q;
  wire                   wr_clk;
  wire                   wr_arg;
  wire                   wr_cmd;
  wire                   cmd_start;

  function is_addr;
    input [7:0] a;
    input [7:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  assign wr_clk = reg_sel_i & reg_wr_i &
                  is_addr(reg_addr_i, `SDCC_OFF_CLKCTRL);
  assign wr_arg = reg_sel_i & reg_wr_i &
                  is_addr(reg_addr_i, `SDCC_OFF_ARG);
  assign wr_cmd = reg_sel_i & reg_wr_i &
                  is_addr(reg_addr_i, `SDCC_OFF_CMD);
  // A new command is only taken while the machine is idle
  assign cmd_start = wr_cmd & reg_wdata_i[`SDCC_CMD_ENABLE] &
                     (state_q == ST_IDLE);

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clkctrl_q   <= `SDCC_RST_CLKCTRL;
      arg_q       <= `SDCC_RST_ARG;
      cmd_q       <= `SDCC_RST_CMD;
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wr_clk) begin
        clkctrl_q <= reg_wdata_i[`SDCC_CLK_MSB:0];
      end
      if (wr_arg) begin
        arg_q <= reg_wdata_i;
      end
      if (wr_cmd) begin
        cmd_q <= reg_wdata_i[`SDCC_CMD_MSB:0];
      end
      reg_rdata_o <= 32'h0000_0000;
      if (reg_sel_i && !reg_wr_i) begin
        case (reg_addr_i)
          `SDCC_OFF_CLKCTRL: reg_rdata_o <= {17'h0_0000, clkctrl_q};
          `SDCC_OFF_ARG:     reg_rdata_o <= arg_q;
          `SDCC_OFF_CMD:     reg_rdata_o <= {17'h0_0000, cmd_q};
          `SDCC_OFF_RESPIDX: reg_rdata_o <= {26'h000_0000, resp_idx_q};
          default:           reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Card clock
  wire clk_run;
  wire drive_tick;
  wire sample_tick;
  wire bus_active;

  assign bus_active = (state_q != ST_IDLE) | data_busy_i;
  assign clk_run = clkctrl_q[`SDCC_CLK_EN] &
                   ~read_wait_stop_i &
                   ~(clkctrl_q[`SDCC_CLK_FLOW] & data_stall_i) &
                   (clkctrl_q[`SDCC_CLK_GATE] | bus_active);

  sdcc_clkgen u_clkgen (
    .clk_i         (ref_clk_i),
    .rst_n_i       (rst_n),
    .ce_i          (ce_i),
    .run_i         (clk_run),
    .div_i         (clkctrl_q[`SDCC_CLK_DIV_MSB:0]),
    .bypass_i      (clkctrl_q[`SDCC_CLK_BYPASS]),
    .edge_i        (clkctrl_q[`SDCC_CLK_EDGE]),
    .card_clk_o    (card_clk_o),
    .drive_tick_o  (drive_tick),
    .sample_tick_o (sample_tick)
  );

  // ==========================================================
  // Command path machine
  reg  [39:0] tx_sr_q;
  reg  [7:0]  bit_cnt_q;
  reg  [7:0]  tmo_cnt_q;
  reg  [5:0]  idx_sr_q;
  reg         crc_bad_q;
  reg         crc_clr;
  reg         crc_en;
  reg         crc_shift;
  reg         crc_din;
  wire [6:0]  crc;
  wire [1:0]  wait_type;
  wire        resp_long;
  wire        resp_none;
  wire [7:0]  resp_bits;
  wire [7:0]  crc_lo;
  wire [7:0]  crc_hi;
  wire        in_crc_body;
  wire        in_crc_cmp;

  assign wait_type = cmd_q[`SDCC_CMD_WAIT_MSB:`SDCC_CMD_WAIT_LSB];
  assign resp_none = ~wait_type[0];
  assign resp_long = wait_type[1] & wait_type[0];
  assign resp_bits = resp_long ? `SDCC_LONG_BITS
                               : `SDCC_SHORT_BITS;
  assign crc_lo = resp_long ? `SDCC_LONG_CRC_LO : `SDCC_SHORT_CRC_LO;
  assign crc_hi = resp_long ? `SDCC_LONG_CRC_HI : `SDCC_SHORT_CRC_HI;
  assign in_crc_body = (bit_cnt_q >= crc_lo) && (bit_cnt_q <= crc_hi);
  assign in_crc_cmp  = (bit_cnt_q > crc_hi) &&
                       (bit_cnt_q < resp_bits - 8'h01);

  always @* begin
    crc_clr   = 1'b0;
    crc_en    = 1'b0;
    crc_shift = 1'b0;
    crc_din   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        crc_clr = 1'b1;
      end
      ST_SEND: begin
        if (drive_tick && bit_cnt_q < 8'h28) begin
          crc_en  = 1'b1;
          crc_din = tx_sr_q[39];
        end else if (drive_tick && bit_cnt_q < 8'h2f) begin
          crc_shift = 1'b1;
        end else if (drive_tick && bit_cnt_q == `SDCC_CMD_BITS) begin
          crc_clr = 1'b1;
        end
      end
      ST_WAIT: begin
        // Start bit counts toward the short response check
        crc_en  = sample_tick & ~cmd_i & ~resp_long;
        crc_din = 1'b0;
      end
      ST_RECV: begin
        crc_en    = sample_tick & in_crc_body;
        crc_din   = cmd_i;
        crc_shift = sample_tick & in_crc_cmp;
      end
      default: begin
        crc_clr = 1'b1;
      end
    endcase
  end

  sdcc_crc7 u_crc (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .clr_i   (crc_clr),
    .en_i    (crc_en),
    .shift_i (crc_shift),
    .din_i   (crc_din),
    .crc_o   (crc)
  );

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q         <= ST_IDLE;
      tx_sr_q         <= 40'h00_0000_0000;
      bit_cnt_q       <= 8'h00;
      tmo_cnt_q       <= 8'h00;
      idx_sr_q        <= 6'h00;
      crc_bad_q       <= 1'b0;
      resp_idx_q      <= `SDCC_RST_RESPIDX;
      cmd_o           <= 1'b1;
      cmd_oe_o        <= 1'b0;
      cmd_sent_o      <= 1'b0;
      resp_recv_o     <= 1'b0;
      resp_crc_fail_o <= 1'b0;
      resp_timeout_o  <= 1'b0;
      irq_seen_o      <= 1'b0;
      cmd_done_o      <= 1'b0;
    end else if (ce_i) begin
      cmd_sent_o      <= 1'b0;
      resp_recv_o     <= 1'b0;
      resp_crc_fail_o <= 1'b0;
      resp_timeout_o  <= 1'b0;
      irq_seen_o      <= 1'b0;
      cmd_done_o      <= 1'b0;
      if (state_q != ST_IDLE && !cmd_q[`SDCC_CMD_ENABLE]) begin
        state_q  <= ST_IDLE;
        cmd_oe_o <= 1'b0;
        cmd_o    <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            bit_cnt_q <= 8'h00;
            if (cmd_start) begin
              tx_sr_q <= {2'b01,
                          reg_wdata_i[`SDCC_CMD_IDX_MSB:0],
                          arg_q};
              if (reg_wdata_i[`SDCC_CMD_WAITEND]) begin
                state_q <= ST_PEND;
              end else begin
                state_q <= ST_SEND;
              end
            end
          end
          ST_PEND: begin
            if (!data_busy_i) begin
              state_q <= ST_SEND;
            end
          end
          ST_SEND: begin
            if (drive_tick) begin
              bit_cnt_q <= bit_cnt_q + 8'h01;
              cmd_oe_o  <= 1'b1;
              if (bit_cnt_q < 8'h28) begin
                cmd_o   <= tx_sr_q[39];
                tx_sr_q <= {tx_sr_q[38:0], 1'b0};
              end else if (bit_cnt_q < 8'h2f) begin
                cmd_o <= crc[6];
              end else if (bit_cnt_q < `SDCC_CMD_BITS) begin
                cmd_o <= 1'b1;
              end else begin
                cmd_oe_o  <= 1'b0;
                bit_cnt_q <= 8'h00;
                tmo_cnt_q <= 8'h00;
                crc_bad_q <= 1'b0;
                if (resp_none) begin
                  state_q    <= ST_IDLE;
                  cmd_sent_o <= 1'b1;
                  cmd_done_o <= cmd_q[`SDCC_CMD_CPL];
                end else begin
                  state_q <= ST_WAIT;
                end
              end
            end
          end
          ST_WAIT: begin
            if (sample_tick && !cmd_i) begin
              state_q   <= ST_RECV;
              bit_cnt_q <= 8'h01;
            end else if (!cmd_q[`SDCC_CMD_WAITIRQ] && card_irq_i) begin
              state_q    <= ST_IDLE;
              irq_seen_o <= 1'b1;
              cmd_done_o <= cmd_q[`SDCC_CMD_CPL];
            end else if (sample_tick && cmd_q[`SDCC_CMD_WAITIRQ]) begin
              tmo_cnt_q <= tmo_cnt_q + 8'h01;
              if (tmo_cnt_q == `SDCC_RESP_TIMEOUT - 8'h01) begin
                state_q        <= ST_IDLE;
                resp_timeout_o <= 1'b1;
                cmd_done_o     <= cmd_q[`SDCC_CMD_CPL];
              end
            end
          end
          ST_RECV: begin
            if (sample_tick) begin
              bit_cnt_q <= bit_cnt_q + 8'h01;
              if (bit_cnt_q < 8'h08) begin
                idx_sr_q <= {idx_sr_q[4:0], cmd_i};
              end
              if (bit_cnt_q == 8'h08) begin
                resp_idx_q <= idx_sr_q;
              end
              if (in_crc_cmp && cmd_i != crc[6]) begin
                crc_bad_q <= 1'b1;
              end
              if (bit_cnt_q == resp_bits - 8'h01) begin
                state_q         <= ST_IDLE;
                resp_recv_o     <= ~crc_bad_q;
                resp_crc_fail_o <= crc_bad_q;
                cmd_done_o      <= cmd_q[`SDCC_CMD_CPL];
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Control outputs decoded from registers, and busy flags from state
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_lanes_o   <= `SDCC_LANES_1;
      flow_ctrl_en_o <= 1'b0;
      cmd_irq_en_o   <= 1'b0;
      busy_o         <= 1'b0;
      suspend_cmd_o  <= 1'b0;
      ata_cmd_o      <= 1'b0;
    end else if (ce_i) begin
      case (clkctrl_q[`SDCC_CLK_WID_MSB:`SDCC_CLK_WID_LSB])
        2'h1:    data_lanes_o <= `SDCC_LANES_4;
        2'h2:    data_lanes_o <= `SDCC_LANES_8;
        // Reserved code falls back to one lane
        default: data_lanes_o <= `SDCC_LANES_1;
      endcase
      flow_ctrl_en_o <= clkctrl_q[`SDCC_CLK_FLOW];
      cmd_irq_en_o   <= ~cmd_q[`SDCC_CMD_IRQEN];
      busy_o         <= (state_q != ST_IDLE);
      suspend_cmd_o  <= (state_q != ST_IDLE) &
                        cmd_q[`SDCC_CMD_SUSPEND];
      ata_cmd_o      <= (state_q != ST_IDLE) &
                        cmd_q[`SDCC_CMD_ATA];
    end
  end

endmodule

// *** rtl/unused_placeholder_none.v ***
// Reserved file; holds no logic.

// *** test/sdcc_card_model.sv ***
// Card model: takes host command frames and answers on the command line.
// Assumes the bench resolves the line with a pull-up when nobody drives.
`timescale 1ns/1ps
module sdcc_card_model (
  input  wire        card_clk_i,
  input  wire        line_i,
  input  wire        host_oe_i,
  input  wire  [2:0] mode_i,
  output logic       bit_o,
  output logic       oe_o
);
  // ==========================================================
  // Receive and answer
  logic [47:0]  rx_frame;
  logic [135:0] tx;
  int           rx_n;
  int           len;

  function automatic logic [6:0] crc7(input logic [135:0] v, input int n);
    logic [6:0] c;
    c = 7'h00;
    for (int i = n - 1; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ (((v[i] ^ c[6]) == 1'b1) ? 7'h09 : 7'h00);
    return c;
  endfunction

  // Modes: 0 silent, 1 short, 2 long, 3 short bad CRC, 4 slow short
  initial begin
    bit_o = 1'b1;
    oe_o = 1'b0;
    rx_n = 0;
    forever begin
      @(posedge card_clk_i);
      if (host_oe_i !== 1'b1) rx_n = 0;
      else if ((rx_n > 0 || line_i === 1'b0) && rx_n < 48) begin
        rx_frame = {rx_frame[46:0], line_i};
        rx_n++;
      end
      if (rx_n == 48 && mode_i != 3'd0) begin
        rx_n = 0;
        if (mode_i == 3'd2) begin
          tx = {2'b00, 6'h3f, rx_frame[39:0], ~rx_frame[39:0],
                rx_frame[39:0], 8'h01};
          tx[7:1] = crc7({16'h0000, tx[127:8]}, 120);
          len = 136;
        end else begin
          tx = {88'h0, 2'b00, rx_frame[45:40], ~rx_frame[39:8], 8'h01};
          tx[7:1] = crc7({96'h0, tx[47:8]}, 40);
          len = 48;
        end
        if (mode_i == 3'd3) tx[1] = ~tx[1];
        repeat ((mode_i == 3'd4) ? 9 : 2) @(negedge card_clk_i);
        for (int i = len - 1; i >= 0; i--) begin
          @(negedge card_clk_i);
          oe_o = 1'b1;
          bit_o = tx[i];
        end
        @(negedge card_clk_i);
        oe_o = 1'b0;
      end
    end
  end
endmodule

// *** test/sdcc_top_bench.sv ***
// Self-checking bench for the card clock and command path.
// Assumes the card model and the port checker are compiled alongside.
`timescale 1ns/1ps
`define SDCC_CHK(nm, ex, got) begin checks_done++; \
  if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module sdcc_top_bench;
  // ==========================================================
  // Ports, line resolution and instances
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, reg_sel_i = 1'b0, reg_wr_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic data_busy_i = 1'b0, data_stall_i = 1'b0, read_wait_stop_i = 1'b0;
  logic card_irq_i = 1'b0, ce_i = 1'b1;
  logic [2:0]  card_mode = 3'd0;
  wire  [31:0] reg_rdata_o;
  wire  [7:0]  data_lanes_o;
  wire cmd_o, cmd_oe_o, card_clk_o, flow_ctrl_en_o, cmd_irq_en_o, busy_o;
  wire suspend_cmd_o, ata_cmd_o, cmd_sent_o, resp_recv_o, resp_crc_fail_o;
  wire resp_timeout_o, irq_seen_o, cmd_done_o, card_bit, card_oe;
  int miscompares = 0, checks_done = 0;
  // Pull-up on the command line when neither side drives
  wire cmd_line = cmd_oe_o ? cmd_o : (card_oe ? card_bit : 1'b1);

  sdcc_top sdcc_top_inst (.cmd_i(cmd_line), .*);
  sdcc_card_model sdcc_card_model_inst (.card_clk_i(card_clk_o),
    .line_i(cmd_line), .host_oe_i(cmd_oe_o), .mode_i(card_mode),
    .bit_o(card_bit), .oe_o(card_oe));

  always #50 ref_clk_i = ~ref_clk_i;

  task automatic conclude();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    #1 {reg_sel_i, reg_wr_i, reg_addr_i, reg_wdata_i} = {2'b11, a, d};
    @(posedge ref_clk_i);
    #1 {reg_sel_i, reg_wr_i} = 2'b00;
    repeat (7) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    #1 {reg_sel_i, reg_wr_i, reg_addr_i} = {2'b10, a};
    @(posedge ref_clk_i);
    #1 reg_sel_i = 1'b0;
    d = reg_rdata_o;
  endtask

  task automatic edges(input int n, output int e);
    logic p;
    e = 0;
    p = card_clk_o;
    repeat (n) begin
      @(posedge ref_clk_i);
      #1 if (card_clk_o === 1'b1 && p === 1'b0) e++;
      p = card_clk_o;
    end
  endtask

  task automatic wait_flag(input logic irq, output logic [4:0] f,
                           output logic dn);
    f = 5'h00;
    dn = 1'b0;
    for (int i = 0; i < 3000 && f == 5'h00; i++) begin
      @(posedge ref_clk_i);
      #1 card_irq_i = irq && i >= 400;
      f = {cmd_sent_o, resp_recv_o, resp_crc_fail_o, resp_timeout_o,
           irq_seen_o};
      dn = dn | cmd_done_o;
    end
    repeat (3) begin
      @(posedge ref_clk_i);
      #1 dn = dn | cmd_done_o;
    end
    card_irq_i = 1'b0;
  endtask

  task automatic t_regs();
    logic [7:0]  ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] wv [6] = '{'1, '1, 32'ha5c3_0f96, 32'hffff_fbff, '1, '1};
    logic [31:0] ev [6] = '{0, 32'h0000_7fff, 32'ha5c3_0f96,
                            32'h0000_7bff, 0, 0};
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(ad[i], d);
      `SDCC_CHK("reset", 32'h0000_0000, d)
    end
    ce_i = 1'b0;
    wr(8'h08, '1);
    ce_i = 1'b1;
    rd(8'h08, d);
    `SDCC_CHK("ce", 0, d)
    for (int i = 0; i < 6; i++) wr(ad[i], wv[i]);
    for (int i = 0; i < 6; i++) begin
      rd(ad[i], d);
      `SDCC_CHK("readback", ev[i], d)
    end
    `SDCC_CHK("irq_en", 1'b0, cmd_irq_en_o)
    wr(8'h0c, 32'h0000_0000);
    `SDCC_CHK("irq_en", 1'b1, cmd_irq_en_o)
  endtask

  task automatic t_clock();
    logic [33:0] tv [10] = '{34'h0_0000_0300, 34'h0_0000_0304,
      34'h0_0000_030a, 34'h0_0000_070a, 34'h0_0000_2300, 34'h0_0000_0200,
      34'h0_0000_0100, 34'h2_0000_4300, 34'h2_0000_0300, 34'h1_0000_0300};
    int ex [10] = '{60, 20, 10, 60, 60, 0, 0, 0, 60, 0};
    logic [7:0] ln [4] = '{8'h01, 8'h0f, 8'hff, 8'h01};
    int n;
    for (int i = 0; i < 10; i++) begin
      {data_stall_i, read_wait_stop_i} = tv[i][33:32];
      wr(8'h04, tv[i][31:0]);
      edges(120, n);
      `SDCC_CHK("edges", ex[i], n)
    end
    {data_stall_i, read_wait_stop_i} = 2'b00;
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, {17'h0, i[0], 1'b0, i[1:0], 11'h300});
      `SDCC_CHK("lanes", {i[0], ln[i]}, {flow_ctrl_en_o, data_lanes_o})
    end
  endtask

  task automatic t_cmd(input logic [1:0] w, input logic [2:0] m,
    input logic [5:0] idx, input logic b8, input logic cpl,
    input logic [4:0] ef, input logic [5:0] ei);
    logic [4:0]  f;
    logic        dn;
    logic [31:0] d, a;
    logic [47:0] e;
    a = {idx, 2'b10, idx, 6'h15, idx, idx};
    e = {2'b01, idx, a, 8'h01};
    e[7:1] = sdcc_card_model_inst.crc7({88'h0, e[47:8]}, 40);
    card_mode = m;
    wr(8'h08, a);
    wr(8'h0c, {19'h0, cpl, 3'b010, b8, w, idx});
    wait_flag(!b8, f, dn);
    `SDCC_CHK("flags", ef, f)
    `SDCC_CHK("done", cpl, dn)
    `SDCC_CHK("frame", e, sdcc_card_model_inst.rx_frame)
    rd(8'h10, d);
    `SDCC_CHK("resp_idx", {26'h0, ei}, d)
  endtask

  task automatic t_abort();
    wr(8'h0c, 32'h0000_4c21);
    `SDCC_CHK("busy", 3'b111, {busy_o, suspend_cmd_o, ata_cmd_o})
    wr(8'h0c, 32'h0000_0821);
    `SDCC_CHK("abort", 2'b00, {busy_o, cmd_oe_o})
  endtask

  task automatic t_wait_end();
    logic       seen;
    logic [4:0] f;
    logic       dn;
    seen = 1'b0;
    card_mode = 3'd0;
    data_busy_i = 1'b1;
    wr(8'h0c, 32'h0000_0601);
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk_i);
      #1 seen = seen | cmd_oe_o;
    end
    `SDCC_CHK("held", 1'b0, seen)
    data_busy_i = 1'b0;
    wait_flag(1'b0, f, dn);
    `SDCC_CHK("sent", 5'b10000, f)
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    t_regs();
    t_clock();
    // Slow clock keeps model sampling clear of drive ticks; spirit
    wr(8'h04, 32'h0000_0302);
    t_cmd(2'b00, 3'd0, 6'h05, 1'b1, 1'b1, 5'b10000, 6'h00);
    t_cmd(2'b10, 3'd0, 6'h2a, 1'b1, 1'b1, 5'b10000, 6'h00);
    t_cmd(2'b01, 3'd1, 6'h11, 1'b1, 1'b1, 5'b01000, 6'h11);
    t_cmd(2'b11, 3'd2, 6'h02, 1'b1, 1'b1, 5'b01000, 6'h3f);
    t_cmd(2'b01, 3'd3, 6'h3c, 1'b1, 1'b1, 5'b00100, 6'h3c);
    t_cmd(2'b01, 3'd4, 6'h07, 1'b1, 1'b0, 5'b01000, 6'h07);
    t_cmd(2'b01, 3'd0, 6'h09, 1'b1, 1'b1, 5'b00010, 6'h07);
    t_cmd(2'b01, 3'd0, 6'h0b, 1'b0, 1'b1, 5'b00001, 6'h07);
    t_abort();
    t_wait_end();
    conclude();
  end

  initial begin
    #5_000_000;
    miscompares++;
    conclude();
  end
endmodule

// *** test/sdcc_top_checker.sv ***
// Port checker for the card clock and command path.
// Assumes one clock domain and register writes spaced apart.
`timescale 1ns/1ps
module sdcc_top_checker (
  input wire        ref_clk_i,
  input wire        rstn_i,
  input wire        reg_sel_i,
  input wire        reg_wr_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire [31:0] reg_rdata_o,
  input wire        data_stall_i,
  input wire        read_wait_stop_i,
  input wire        cmd_o,
  input wire        cmd_oe_o,
  input wire        card_clk_o,
  input wire [7:0]  data_lanes_o,
  input wire        flow_ctrl_en_o,
  input wire        cmd_irq_en_o,
  input wire        busy_o,
  input wire        suspend_cmd_o,
  input wire        ata_cmd_o,
  input wire        cmd_sent_o,
  input wire        resp_recv_o,
  input wire        resp_crc_fail_o,
  input wire        resp_timeout_o,
  input wire        irq_seen_o
);
  // ==========================================================
  // Helper state
  logic [8:0] per_q;
  logic [8:0] exp_q;
  logic [7:0] lanes_q;
  logic       arm_q;
  logic       prev_q;
  logic       run_q;
  wire wr04 = reg_sel_i && reg_wr_i && reg_addr_i == 8'h04;
  wire wr0c = reg_sel_i && reg_wr_i && reg_addr_i == 8'h0c;
  wire rise = card_clk_o && !prev_q;
  wire [4:0] flags = {cmd_sent_o, resp_recv_o, resp_crc_fail_o,
                      resp_timeout_o, irq_seen_o};

  // Period is only judged between rises with nothing stopping the clock
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      per_q <= 9'h000;
      exp_q <= 9'h002;
      lanes_q <= 8'h01;
      arm_q <= 1'b0;
      prev_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      prev_q <= card_clk_o;
      per_q <= rise ? 9'h001 : per_q + 9'h001;
      if (wr04) begin
        exp_q <= reg_wdata_i[10] ? 9'h002 : {1'b0, reg_wdata_i[7:0]} + 9'h002;
        lanes_q <= (reg_wdata_i[12:11] == 2'b01) ? 8'h0f :
                   (reg_wdata_i[12:11] == 2'b10) ? 8'hff : 8'h01;
        run_q <= &reg_wdata_i[9:8];
      end
      if (wr04 || read_wait_stop_i || data_stall_i) arm_q <= 1'b0;
      else if (rise && run_q) arm_q <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  clk_period_a: assert property (rise && arm_q |-> per_q == exp_q)
    else $error("card clock period wrong");
  rw_stop_a: assert property (read_wait_stop_i [*3] |-> !card_clk_o)
    else $error("card clock runs in read wait");
  lanes_map_a: assert property (wr04 |-> ##2 data_lanes_o == lanes_q)
    else $error("lane enables wrong");
  flow_copy_a: assert property (wr04 |-> ##2
    flow_ctrl_en_o == $past(reg_wdata_i[14], 2)) else $error("flow bit");
  irq_en_inv_a: assert property (wr0c |-> ##2
    cmd_irq_en_o == !$past(reg_wdata_i[13], 2)) else $error("irq enable");
  idx_high_zero_a: assert property (reg_sel_i && !reg_wr_i &&
    reg_addr_i == 8'h10 |=> reg_rdata_o[31:6] == 26'h0)
    else $error("index reserved bits set");
  suspend_busy_a: assert property (suspend_cmd_o |-> busy_o)
    else $error("suspend flag while idle");
  ata_busy_a: assert property (ata_cmd_o |-> busy_o)
    else $error("ata flag while idle");
  flag_pulse_a: assert property ((|flags) |=> !(|flags))
    else $error("flag longer than one cycle");
  flag_onehot_a: assert property ($onehot0(flags))
    else $error("two end flags at once");
  start_bit_a: assert property ($rose(cmd_oe_o) |-> !cmd_o)
    else $error("frame does not open with zero");
  drive_busy_a: assert property (cmd_oe_o |-> busy_o || cmd_o)
    else $error("line driven low while idle");

  cover property (resp_recv_o);
  cover property (resp_timeout_o);
  cover property (irq_seen_o);
  cover property (rise && arm_q);
endmodule

bind sdcc_top sdcc_top_checker sdcc_top_checker_inst (.*);
